// >>> logic/lsea_pkg.sv
// Shared types and constants for the load/store effective-address generator.
// Assumes a decoder that has already read the register file and sorted the instruction into one address mode.

package lsea_pkg;

    // Datapath widths.
    localparam int LSEA_XLEN   = 32;
    localparam int LSEA_DISP_W = 16;
    localparam int LSEA_RIDX_W = 5;

    // Register field that stands for a literal zero in non-update forms.
    localparam logic [LSEA_RIDX_W-1:0] LSEA_REG_ZERO = 5'h00;

    // Reset values of the result and write-back stages.
    localparam logic [LSEA_XLEN-1:0]   LSEA_EA_RST  = 32'h0000_0000;
    localparam logic [LSEA_RIDX_W-1:0] LSEA_REG_RST = 5'h00;

    // Cycles from an accepted request to its result.
    localparam int LSEA_LATENCY = 1;

    // The three address-forming modes.
    typedef enum logic [1:0] {
        LSEA_MODE_DISP,
        LSEA_MODE_INDEX,
        LSEA_MODE_BASE
    } lsea_mode_t;

    // Request from the decoder, operands already read from the register file.
    typedef struct packed {
        logic                   valid;
        lsea_mode_t             mode;
        logic                   is_load;
        logic                   is_string;
        logic                   update;
        logic                   sync;
        logic [LSEA_RIDX_W-1:0] base_reg_field;
        logic [LSEA_RIDX_W-1:0] index_reg_field;
        logic [LSEA_RIDX_W-1:0] dest_reg_field;
        logic [LSEA_DISP_W-1:0] disp;
        logic [LSEA_XLEN-1:0]   base_val;
        logic [LSEA_XLEN-1:0]   index_val;
    } lsea_req_t;

    // Address handed to the load/store unit.
    typedef struct packed {
        logic                 valid;
        logic [LSEA_XLEN-1:0] ea;
        logic                 is_load;
        logic                 strict_order;
        logic                 form_invalid;
        logic                 mode_err;
    } lsea_res_t;

    // Base-register write-back for update forms.
    typedef struct packed {
        logic                   valid;
        logic [LSEA_RIDX_W-1:0] reg_idx;
        logic [LSEA_XLEN-1:0]   data;
    } lsea_wb_t;

endpackage : lsea_pkg

// >>> logic/lsea_adder.sv
// Wrapping 32-bit adder used for every effective-address sum.
// Assumes both operands are already selected; no carry leaves this module.

`timescale 1ns/10ps
`default_nettype none

module lsea_adder
    import lsea_pkg::*;
(
    // Operands.
    input  wire logic [LSEA_XLEN-1:0] op_a,
    input  wire logic [LSEA_XLEN-1:0] op_b,
    // Result.
    output var  logic [LSEA_XLEN-1:0] sum
);

    // The carry out of the top bit is dropped, so addresses wrap.
    always_comb begin
        sum = op_a + op_b;
    end

endmodule : lsea_adder

`default_nettype wire

// >>> logic/lsea_ea_gen.sv
// Effective-address generator for integer loads and stores, one request per clock.
// Assumes the decoder presents operands already read from the register file
// and that the load/store unit and register file accept every result offered.

`timescale 1ns/10ps
`default_nettype none

module lsea_ea_gen
    import lsea_pkg::*;
(
    // Clock and reset.
    input  wire logic      clk_sys,
    input  wire logic      sys_rst,
    // Request from the decoder.
    input  wire lsea_req_t req,
    // Address to the load/store unit.
    output var  lsea_res_t res,
    // Base-register write-back to the register file.
    output var  lsea_wb_t  wb
);

    ////////////////////////////////////////////////////////////////////////////
    // Operand selection.

    logic                 zero_base;
    logic [LSEA_XLEN-1:0] base_op;
    logic [LSEA_XLEN-1:0] addend_op;
    logic [LSEA_XLEN-1:0] ea_sum;
    logic                 mode_bad;
    logic                 form_bad;

    // Update forms always read the base register; the zero substitution only
    // applies to the plain forms, which is why update is part of the test.
    always_comb begin
        zero_base = (req.base_reg_field == LSEA_REG_ZERO) && !req.update;
    end

    // Base operand: literal zero or the register contents.
    always_comb begin
        base_op = zero_base ? LSEA_EA_RST : req.base_val;
    end

    // Second operand chosen by mode; base-only mode adds nothing.
    always_comb begin
        unique case (req.mode)
            LSEA_MODE_DISP: begin
                addend_op = {{(LSEA_XLEN-LSEA_DISP_W){req.disp[LSEA_DISP_W-1]}}, req.disp};
            end
            LSEA_MODE_INDEX: begin
                addend_op = req.index_val;
            end
            LSEA_MODE_BASE: begin
                addend_op = LSEA_EA_RST;
            end
            default: begin
                addend_op = LSEA_EA_RST;
            end
        endcase
    end

    // One adder serves all modes, so timing is the same for each.
    lsea_adder u_adder (
        .op_a (base_op),
        .op_b (addend_op),
        .sum  (ea_sum)
    );

    // Base-only mode is legal only for string instructions, and string
    // instructions use nothing else; an illegal mode code is also flagged.
    always_comb begin
        mode_bad = (req.mode == LSEA_MODE_BASE) != req.is_string;
        if (req.mode != LSEA_MODE_DISP && req.mode != LSEA_MODE_INDEX && req.mode != LSEA_MODE_BASE) begin
            mode_bad = 1'b1;
        end
    end

    // Update loads naming base zero or base equal to destination are
    // invalid; they still complete, with no exception raised.
    always_comb begin
        form_bad = req.update && req.is_load &&
                   ((req.base_reg_field == LSEA_REG_ZERO) ||
                    (req.base_reg_field == req.dest_reg_field));
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result stage to the load/store unit.

    // Each result carries its own ordering demand; the load/store unit may
    // complete unordered results in any order.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            res.valid        <= 1'b0;
            res.ea           <= LSEA_EA_RST;
            res.is_load      <= 1'b0;
            res.strict_order <= 1'b0;
            res.form_invalid <= 1'b0;
            res.mode_err     <= 1'b0;
        end else begin
            res.valid        <= req.valid;
            res.ea           <= ea_sum;
            res.is_load      <= req.is_load;
            res.strict_order <= req.valid && req.sync;
            res.form_invalid <= req.valid && form_bad;
            res.mode_err     <= req.valid && mode_bad;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write-back stage to the register file.

    // The write-back is issued even for invalid forms: the base register then
    // holds a boundedly undefined value, which is cheaper than a trap path.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wb.valid   <= 1'b0;
            wb.reg_idx <= LSEA_REG_RST;
            wb.data    <= LSEA_EA_RST;
        end else begin
            wb.valid   <= req.valid && req.update;
            wb.reg_idx <= req.base_reg_field;
            wb.data    <= ea_sum;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb_sys @(posedge clk_sys);
    endclocking

    default disable iff (sys_rst);

    // Every check below looks one edge after the request. A request that is
    // presented while reset is high must leave no result behind. So no check
    // compares a result with $past of the request across the release edge.

    chk_disp_sum: assert property (
        req.valid && req.mode == LSEA_MODE_DISP && !zero_base
        |=> res.ea == 32'($past(req.base_val) +
                          {{16{$past(req.disp[15])}}, $past(req.disp)}))
        else $error("Displacement address is not base plus extended offset.");

    chk_zero_base: assert property (
        req.valid && req.mode != LSEA_MODE_BASE && !req.update &&
        req.base_reg_field == LSEA_REG_ZERO
        |=> res.ea == ($past(req.mode) == LSEA_MODE_DISP ? {{16{$past(req.disp[15])}}, $past(req.disp)} :
                       $past(req.mode) == LSEA_MODE_INDEX ? $past(req.index_val) :
                       LSEA_EA_RST))
        else $error("Base field zero did not add a literal zero.");

    chk_index_sum: assert property (
        req.valid && req.mode == LSEA_MODE_INDEX && !zero_base
        |=> res.ea == 32'($past(req.base_val) + $past(req.index_val)))
        else $error("Index address is not base plus index.");

    chk_base_only: assert property (
        req.valid && req.mode == LSEA_MODE_BASE && !zero_base
        |=> res.ea == $past(req.base_val))
        else $error("Base-only address differs from base register.");

    chk_base_zero: assert property (
        req.valid && req.mode == LSEA_MODE_BASE && !req.update &&
        req.base_reg_field == LSEA_REG_ZERO
        |=> res.ea == LSEA_EA_RST)
        else $error("Base-only with field zero did not give zero.");

    chk_mode_err: assert property (
        req.valid && ((req.mode == LSEA_MODE_BASE) != req.is_string)
        |=> res.mode_err)
        else $error("Base-only mode misuse was not flagged.");

    chk_wb_match: assert property (
        wb.valid |-> res.valid && wb.data == res.ea &&
                     wb.reg_idx == $past(req.base_reg_field))
        else $error("Write-back does not carry the address to the base.");

    chk_wb_update: assert property (
        req.valid |=> wb.valid == $past(req.update))
        else $error("Write-back issued without an update form.");

    chk_strict_ord: assert property (
        res.strict_order |-> res.valid && $past(req.sync))
        else $error("Ordering demanded without a synchronising request.");

    chk_invalid_form: assert property (
        req.valid && req.update && req.is_load &&
        (req.base_reg_field == LSEA_REG_ZERO || req.base_reg_field == req.dest_reg_field)
        |=> res.form_invalid && res.valid && wb.valid)
        else $error("Invalid update load was not flagged or was dropped.");

    chk_wrap_add: assert property (
        req.valid && req.mode == LSEA_MODE_INDEX && !zero_base &&
        33'(req.base_val) + 33'(req.index_val) > 33'h0_ffff_ffff
        |=> res.ea < $past(req.index_val))
        else $error("Address sum did not wrap at 32 bits.");

    chk_res_valid: assert property (
        req.valid |=> res.valid)
        else $error("Accepted request gave no result.");

    chk_mode_illegal: assert property (
        req.valid && req.mode == lsea_mode_t'(2'h3) |=> res.mode_err)
        else $error("Unused mode code was not flagged.");

    chk_mode_clean: assert property (
        req.valid && (req.is_string ? req.mode == LSEA_MODE_BASE :
                      (req.mode == LSEA_MODE_DISP || req.mode == LSEA_MODE_INDEX))
        |=> !res.mode_err)
        else $error("Legal mode use was flagged as misuse.");

    chk_form_valid: assert property (
        req.valid && !(req.update && req.is_load) |=> !res.form_invalid)
        else $error("Form flagged invalid on a non-update-load request.");

    // Cover points for the main scenarios, so a silent bench shows up as a hole.
    cov_disp_neg: cover property (
        req.valid && req.mode == LSEA_MODE_DISP && req.disp[15] ##1 res.valid);

    cov_index_upd: cover property (
        req.valid && req.mode == LSEA_MODE_INDEX && req.update ##1 wb.valid);

    cov_string_zero: cover property (
        req.valid && req.mode == LSEA_MODE_BASE && req.is_string &&
        req.base_reg_field == LSEA_REG_ZERO);

    cov_sync_req: cover property (req.valid && req.sync ##1 res.strict_order);

    cov_mode_bad: cover property (
        req.valid && req.mode == lsea_mode_t'(2'h3) ##1 res.mode_err);

endmodule : lsea_ea_gen

`default_nettype wire

// >>> dv/lsea_dec_model.sv
// Decoder and register-file stand-in in front of the address generator.
// Assumes the bench drives decoded fields; operand values are filled in here.
`timescale 1ns/10ps
`default_nettype none

module lsea_dec_model
    import lsea_pkg::*;
(
    // Decoded command, operand values ignored.
    input  wire lsea_req_t cmd,
    // Request with operands read.
    output var  lsea_req_t req
);
    // Each register holds a pattern unique to its number; register zero is non-zero so substitution shows.
    always_comb begin
        req           = cmd;
        req.base_val  = 32'hffff_ff00 + {23'h0, cmd.base_reg_field, 4'h0};
        req.index_val = {15'h0, cmd.index_reg_field, 12'h010};
    end
endmodule : lsea_dec_model

`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the effective-address generator.
// Assumes lsea_dec_model fills in register contents from field numbers.
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import lsea_pkg::*;
    logic      clk_sys = 1'b0;
    logic      sys_rst = 1'b1;
    lsea_req_t cmd     = '0;
    lsea_req_t req;
    lsea_res_t res;
    lsea_wb_t  wb;
    int        n_fail  = 0;
    int        checked = 0;
    int        cycles  = 0;

    // Free-running clock at 100 MHz.
    always #5 clk_sys = ~clk_sys;

    lsea_dec_model i_dec (.cmd(cmd), .req(req));
    lsea_ea_gen i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .req(req), .res(res), .wb(wb));

    ////////////////////////////////////////
    // Compare one value and count it.
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Issue one request, then judge the result pulse against values worked out here.
    task automatic go(input lsea_mode_t m, input logic s, u, l, y, input logic [4:0] bf, xf, df,
                      input logic [15:0] d);
        logic [31:0] b;
        logic [31:0] e;
        b = (bf == 5'h00 && !u) ? 32'h0 : 32'hffff_ff00 + {23'h0, bf, 4'h0};
        e = (m == LSEA_MODE_DISP) ? b + {{16{d[15]}}, d} :
            (m == LSEA_MODE_INDEX) ? b + {15'h0, xf, 12'h010} : b;
        @(posedge clk_sys);
        cmd <= '{valid: 1'b1, mode: m, is_string: s, update: u, is_load: l, sync: y, base_reg_field: bf,
                 index_reg_field: xf, dest_reg_field: df, disp: d, default: '0};
        @(posedge clk_sys);
        cmd.valid <= 1'b0;
        #1;
        chk("res.valid", 32'(res.valid), 32'h1);
        chk("res.ea", res.ea, e);
        chk("res.is_load", 32'(res.is_load), 32'(l));
        chk("res.strict_order", 32'(res.strict_order), 32'(y));
        chk("res.form_invalid", 32'(res.form_invalid), 32'(u && l && (bf == 5'h00 || bf == df)));
        chk("res.mode_err", 32'(res.mode_err), 32'(((m == LSEA_MODE_BASE) != s) || m == lsea_mode_t'(2'h3)));
        chk("wb.valid", 32'(wb.valid), 32'(u));
        if (u) begin
            chk("wb.reg_idx", 32'(wb.reg_idx), 32'(bf));
            chk("wb.data", wb.data, e);
        end
        // The result must stand for one cycle only.
        @(posedge clk_sys);
        #1;
        chk("res.valid idle", 32'(res.valid | wb.valid), 32'h0);
    endtask : go

    ////////////////////////////////////////
    task automatic t_disp();
        go(LSEA_MODE_DISP, 0, 0, 1, 0, 5'h03, 5'h00, 5'h01, 16'h0100);
        go(LSEA_MODE_DISP, 0, 0, 0, 0, 5'h00, 5'h00, 5'h01, 16'h8000);
        $display("test disp done");
    endtask : t_disp

    task automatic t_index();
        go(LSEA_MODE_INDEX, 0, 0, 1, 0, 5'h05, 5'h07, 5'h01, 16'h0000);
        go(LSEA_MODE_INDEX, 0, 0, 0, 0, 5'h00, 5'h1f, 5'h01, 16'h0000);
        go(LSEA_MODE_INDEX, 0, 0, 1, 0, 5'h1f, 5'h1f, 5'h01, 16'h0000);
        $display("test index done");
    endtask : t_index

    task automatic t_base();
        go(LSEA_MODE_BASE, 1, 0, 1, 0, 5'h09, 5'h02, 5'h01, 16'h1234);
        go(LSEA_MODE_BASE, 1, 0, 0, 0, 5'h00, 5'h02, 5'h01, 16'h1234);
        go(LSEA_MODE_BASE, 0, 0, 1, 0, 5'h09, 5'h02, 5'h01, 16'h0000);
        go(LSEA_MODE_DISP, 1, 0, 1, 0, 5'h09, 5'h02, 5'h01, 16'h0004);
        go(lsea_mode_t'(2'h3), 0, 0, 1, 0, 5'h09, 5'h02, 5'h01, 16'h0000);
        $display("test base done");
    endtask : t_base

    task automatic t_update();
        go(LSEA_MODE_DISP, 0, 1, 1, 0, 5'h04, 5'h00, 5'h06, 16'hfffc);
        go(LSEA_MODE_INDEX, 0, 1, 0, 0, 5'h00, 5'h03, 5'h06, 16'h0000);
        go(LSEA_MODE_DISP, 0, 1, 1, 0, 5'h06, 5'h00, 5'h06, 16'h0010);
        go(LSEA_MODE_INDEX, 0, 1, 1, 0, 5'h00, 5'h02, 5'h06, 16'h0000);
        $display("test update done");
    endtask : t_update

    task automatic t_sync();
        go(LSEA_MODE_INDEX, 0, 0, 0, 1, 5'h02, 5'h04, 5'h01, 16'h0000);
        go(LSEA_MODE_DISP, 0, 0, 1, 1, 5'h02, 5'h00, 5'h01, 16'h7fff);
        $display("test sync done");
    endtask : t_sync

    // A request held while reset is high in mid-run must leave no result behind.
    task automatic t_reset();
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        cmd     <= '{valid: 1'b1, update: 1'b1, mode: LSEA_MODE_INDEX, base_reg_field: 5'h02, default: '0};
        @(posedge clk_sys);
        @(posedge clk_sys);
        cmd.valid <= 1'b0;
        sys_rst   <= 1'b0;
        #1;
        chk("res.valid in reset", 32'(res.valid | wb.valid), 32'h0);
        @(posedge clk_sys);
        #1;
        chk("res.valid after release", 32'(res.valid | wb.valid), 32'h0);
        $display("test reset done");
    endtask : t_reset

    ////////////////////////////////////////
    // Print the counts and the verdict, then stop.
    task automatic summarize();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    // Cut a hang short; the tests need well under a hundred cycles.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            n_fail++;
            summarize();
        end
    end

    // Reset for six cycles, then run every scenario.
    initial begin
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk("res.valid after reset", 32'(res.valid | wb.valid), 32'h0);
        t_disp();
        t_index();
        t_base();
        t_update();
        t_sync();
        t_reset();
        summarize();
    end
endmodule : testbench

`default_nettype wire
